// ==== rtl/aux_adc_pkg.sv ====
// Constants and carrier types for the auxiliary converter sequencer.
// Assumes an on-chip register port behind the serial interface, one byte per address.
package aux_adc_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int          ADDR_W               = 14;
  localparam logic [13:0] OFS_SOURCE_SELECT    = 14'h0301;
  localparam logic [13:0] OFS_CONTROL          = 14'h0302;
  localparam logic [13:0] OFS_STATUS           = 14'h0303;
  localparam logic [13:0] OFS_RESULT           = 14'h0304;

  localparam logic [7:0]  RST_SOURCE_SELECT    = 8'h00;
  localparam logic [7:0]  RST_CONTROL          = 8'h00;
  localparam logic [7:0]  RST_RESULT           = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED          = 8'h00;

  // ---------------------------------------------------------------
  // Field layouts
  // ---------------------------------------------------------------
  localparam int          CTL_ENABLE_BIT       = 0;
  localparam int          CTL_START_BIT        = 1;
  localparam int          CTL_RANGE_BIT        = 2;
  localparam int          CTL_LOG_BIT          = 3;
  localparam int          CTL_DIV_LSB          = 4;
  localparam int          CTL_DIV_MSB          = 7;
  localparam int          STS_EOC_BIT          = 0;
  localparam int          STS_BUSY_BIT         = 1;
  localparam int          RESULT_W             = 8;
  localparam int          DIV_W                = 4;

  // ---------------------------------------------------------------
  // Source select codes
  // ---------------------------------------------------------------
  localparam logic [7:0]  SRC_SENSOR_TO_PIN    = 8'h06;
  localparam logic [7:0]  SRC_SENSOR_TO_CONV   = 8'h0E;
  localparam logic [7:0]  SRC_PIN_TO_CONV      = 8'h0F;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int          CONV_CLOCKS_DEFAULT  = 10;
  localparam logic [3:0]  DIV_ZERO_SUBST       = 4'h1;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [13:0]       addr;
    logic [7:0]        wdata;
  } reg_req_t;

  typedef struct packed {
    logic              sensor_enable;
    logic              sensor_to_pin;
    logic              sensor_to_conv;
    logic              pin_to_conv;
    logic              conv_enable;
    logic              range_full;
    logic              log_response;
    logic              sample;
  } afe_ctrl_t;

  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_CONVERT = 1'b1
  } conv_state_t;

endpackage

// ==== rtl/aux_converter_sequencer.sv ====
// Control logic of the auxiliary 8-bit converter and temperature sensor routing.
// Assumes a synchronous byte register port and an analog core that presents its
// quantized code on analog_code by the last conversion clock edge.
// Summary of operation
// - Source code 0x06 at 0x301 sends the sensor voltage out on the analog pin.
// - Source code 0x0E ties the sensor output to the converter input.
// - Source code 0x0F ties the analog pin to the converter input.
// - Each finished conversion leaves one unsigned 8-bit code in the result register.
// - The converter runs only while control bit 0 at 0x302 is set.
// - A 0 then 1 written to control bit 1 starts exactly one conversion if none is running.
// - Status at 0x303 shows end of conversion in bit 0 and busy in bit 1.
// - The finished code is readable at 0x304 once status shows completion.
// - Control bit 2 picks the 1.2 V span at 0 and the 2.3 V span at 1.
// - Control bit 3 picks a linear response at 0 and a logarithmic one at 1.
// - The converter clock is the reference clock over twice the divider in bits 7 to 4.
// - A high power-down pin disables converter and sensor until it goes low again.
module aux_converter_sequencer
  import aux_adc_pkg::*;
#(
  parameter int unsigned CONV_CLOCKS = aux_adc_pkg::CONV_CLOCKS_DEFAULT
)
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst,
  // Register port
  input  aux_adc_pkg::reg_req_t     req,
  output logic [7:0]                rdata,
  // Pins
  input  wire logic                 power_down_pin,
  // Analog core
  input  wire logic [7:0]           analog_code,
  output aux_adc_pkg::afe_ctrl_t    afe,
  output logic                      converter_clk
);
  import aux_adc_pkg::*;

  localparam int CW = $clog2(CONV_CLOCKS + 1);

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  logic [7:0]        source_select;
  logic [7:0]        control;
  logic [7:0]        result;
  logic              eoc;
  logic              busy;
  logic              start_prev;
  conv_state_t       state;
  conv_state_t       next_state;
  logic [DIV_W-1:0]  div_cnt;
  logic [CW-1:0]     edge_cnt;

  function automatic logic hit(input reg_req_t r, input logic [13:0] ofs);
    hit = r.addr == ofs;
  endfunction

  wire logic wr_source  = req.wr && hit(req, OFS_SOURCE_SELECT);
  wire logic wr_control = req.wr && hit(req, OFS_CONTROL);

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      source_select <= RST_SOURCE_SELECT;
      control       <= RST_CONTROL;
    end
    else
    begin
      if (wr_source)
        source_select <= req.wdata;
      if (wr_control)
        control <= req.wdata;
    end
  end

  // ---------------------------------------------------------------
  // Routing and analog controls
  // ---------------------------------------------------------------
  wire logic             enable_bit   = control[CTL_ENABLE_BIT];
  wire logic             start_bit    = control[CTL_START_BIT];
  wire logic [DIV_W-1:0] div_field    = control[CTL_DIV_MSB:CTL_DIV_LSB];
  wire logic             active       = enable_bit && !power_down_pin;
  wire logic             route_s_pin  = source_select == SRC_SENSOR_TO_PIN;
  wire logic             route_s_conv = source_select == SRC_SENSOR_TO_CONV;
  wire logic             route_p_conv = source_select == SRC_PIN_TO_CONV;

  assign afe.sensor_enable  = (route_s_pin || route_s_conv) && !power_down_pin;
  assign afe.sensor_to_pin  = route_s_pin && !power_down_pin;
  assign afe.sensor_to_conv = route_s_conv && !power_down_pin;
  assign afe.pin_to_conv    = route_p_conv && !power_down_pin;
  assign afe.conv_enable    = active;
  assign afe.range_full     = control[CTL_RANGE_BIT];
  assign afe.log_response   = control[CTL_LOG_BIT];
  assign afe.sample         = busy;

  // ---------------------------------------------------------------
  // Conversion clock divider
  // ---------------------------------------------------------------
  // A zero divider would stop the clock, so it behaves as one
  wire logic [DIV_W-1:0] eff_div   = (div_field == '0) ? DIV_ZERO_SUBST : div_field;
  wire logic             div_wrap  = div_cnt == eff_div - DIV_ZERO_SUBST;
  wire logic             tick_rise = active && div_wrap && !converter_clk;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt       <= '0;
      converter_clk <= 1'b0;
    end
    else if (!active)
    begin
      div_cnt       <= '0;
      converter_clk <= 1'b0;
    end
    else if (div_wrap)
    begin
      div_cnt       <= '0;
      converter_clk <= !converter_clk;
    end
    else
      div_cnt <= div_cnt + DIV_ZERO_SUBST;
  end

  // ---------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------
  wire logic start_edge = start_bit && !start_prev;
  wire logic last_edge  = edge_cnt == CW'(CONV_CLOCKS - 1);
  wire logic conv_go    = (state == ST_IDLE) && start_edge && active;
  wire logic conv_done  = (state == ST_CONVERT) && active && tick_rise && last_edge;
  wire logic conv_abort = (state == ST_CONVERT) && !active;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
        if (conv_go)
          next_state = ST_CONVERT;
      ST_CONVERT:
        if (conv_abort || conv_done)
          next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      state      <= ST_IDLE;
      start_prev <= 1'b0;
      edge_cnt   <= '0;
    end
    else
    begin
      state      <= next_state;
      start_prev <= start_bit;
      if (conv_go)
        edge_cnt <= '0;
      else if (state == ST_CONVERT && tick_rise)
        edge_cnt <= edge_cnt + CW'(1);
    end
  end

  // Start only comes from idle, so it never meets a completion
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      eoc    <= 1'b0;
      busy   <= 1'b0;
      result <= RST_RESULT;
    end
    else if (conv_go)
    begin
      eoc  <= 1'b0;
      busy <= 1'b1;
    end
    else if (conv_done)
    begin
      eoc    <= 1'b1;
      busy   <= 1'b0;
      result <= analog_code;
    end
    else if (conv_abort)
      busy <= 1'b0;
  end

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [7:0] status_word;
  logic [7:0] next_rdata;

  always_comb
  begin
    status_word               = '0;
    status_word[STS_EOC_BIT]  = eoc;
    status_word[STS_BUSY_BIT] = busy;
  end

  assign next_rdata = hit(req, OFS_SOURCE_SELECT) ? source_select :
                      hit(req, OFS_CONTROL)       ? control       :
                      hit(req, OFS_STATUS)        ? status_word   :
                      hit(req, OFS_RESULT)        ? result        : RD_UNMAPPED;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      rdata <= RD_UNMAPPED;
    else if (req.rd)
      rdata <= next_rdata;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  logic [DIV_W-1:0] phase_len;
  logic             phase_valid;
  logic             clk_seen;

  // Length of each converter clock level in reference cycles
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      phase_len   <= '0;
      phase_valid <= 1'b0;
      clk_seen    <= 1'b0;
    end
    else
    begin
      clk_seen <= converter_clk;
      if (!active || wr_control)
      begin
        phase_len   <= '0;
        phase_valid <= 1'b0;
      end
      else if (converter_clk != clk_seen)
      begin
        phase_len   <= 4'h1;
        phase_valid <= 1'b1;
      end
      else
        phase_len <= phase_len + 4'h1;
    end
  end

  a_route_sensor_pin: assert property (
    source_select == 8'h06 && !power_down_pin |-> afe.sensor_to_pin && !afe.sensor_to_conv
  ) else $error("sensor not routed to analog pin");

  a_route_sensor_conv: assert property (
    source_select == 8'h0E && !power_down_pin |-> afe.sensor_to_conv && !afe.pin_to_conv
  ) else $error("sensor not routed to converter");

  a_route_pin_conv: assert property (
    source_select == 8'h0F && !power_down_pin |-> afe.pin_to_conv && !afe.sensor_to_pin
  ) else $error("analog pin not routed to converter");

  a_result_from_done: assert property (
    $changed(result) |-> $past(conv_done) && result == $past(analog_code)
  ) else $error("result changed without a finished conversion");

  a_busy_needs_enable: assert property (
    busy |-> $past(enable_bit)
  ) else $error("busy without the enable bit");

  a_start_one_conv: assert property (
    $rose(start_bit) && !$past(busy) && active && state == ST_IDLE |=> busy && !eoc
  ) else $error("start edge did not begin a conversion");

  a_status_readback: assert property (
    req.rd && req.addr == 14'h0303 |=> rdata == {6'h00, $past(busy), $past(eoc)}
  ) else $error("status read mismatch");

  a_done_flags_data: assert property (
    conv_done |=> eoc && !busy && result == $past(analog_code)
  ) else $error("completion flags wrong");

  a_range_log_sel: assert property (
    wr_control |=> afe.range_full == $past(req.wdata[2]) && afe.log_response == $past(req.wdata[3])
  ) else $error("range or response select not applied");

  a_clock_half_period: assert property (
    phase_valid && active && !wr_control && converter_clk != clk_seen |-> phase_len == eff_div
  ) else $error("converter clock half period wrong");

  a_power_down_stop: assert property (
    power_down_pin |-> !afe.conv_enable && !afe.sensor_enable ##1 !busy && !converter_clk
  ) else $error("power down did not disable converter");

  c_full_conversion: cover property (conv_go ##[1:1000] conv_done);
  c_power_abort:     cover property (busy && power_down_pin ##1 !busy);
  c_result_read:     cover property (eoc && req.rd && req.addr == OFS_RESULT);
  c_start_refused:   cover property (start_edge && !active && state == ST_IDLE);

endmodule

// ==== testbench/tb.sv ====
// Self-checking bench for the auxiliary converter sequencer.
// Assumes the design package and module under rtl/; the bench drives every input port itself.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import aux_adc_pkg::*;

  // ---------------------------------------------------------------
  // Signals and instance
  // ---------------------------------------------------------------
  localparam int CONV_N = 4;
  logic        ref_clk;
  logic        rst;
  reg_req_t    req;
  logic [7:0]  rdata;
  logic        power_down_pin;
  logic [7:0]  analog_code;
  afe_ctrl_t   afe;
  logic        converter_clk;
  logic [7:0]  v;
  int          miscompares;
  int          comparisons;
  int          cycles;

  aux_converter_sequencer #(.CONV_CLOCKS(CONV_N)) aux_converter_sequencer_inst (
    .ref_clk        (ref_clk),
    .rst            (rst),
    .req            (req),
    .rdata          (rdata),
    .power_down_pin (power_down_pin),
    .analog_code    (analog_code),
    .afe            (afe),
    .converter_clk  (converter_clk)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard, far beyond the expected few hundred cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      miscompares++;
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge ref_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic start_conv(input logic [3:0] div);
    wr(OFS_CONTROL, {div, 4'h1});
    wr(OFS_CONTROL, {div, 4'h3});
  endtask

  // Polls status until finished, bounded
  task automatic wait_done();
    for (int i = 0; i < 100; i++)
    begin
      rd(OFS_STATUS, v);
      if (v === 8'h01)
        break;
    end
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    rd(OFS_SOURCE_SELECT, v); chk("source", RST_SOURCE_SELECT, v);
    rd(OFS_CONTROL, v);       chk("control", RST_CONTROL, v);
    rd(OFS_STATUS, v);        chk("status", 8'h00, v);
    rd(OFS_RESULT, v);        chk("result", RST_RESULT, v);
    rd(14'h0300, v);          chk("unmapped", RD_UNMAPPED, v);
    wr(OFS_STATUS, 8'hFF);
    wr(OFS_RESULT, 8'hFF);
    rd(OFS_STATUS, v);        chk("status ro", 8'h00, v);
    rd(OFS_RESULT, v);        chk("result ro", RST_RESULT, v);
  endtask

  task automatic t_source();
    logic [7:0] codes [4] = '{8'h06, 8'h0E, 8'h0F, 8'h03};
    foreach (codes[i])
    begin
      wr(OFS_SOURCE_SELECT, codes[i]);
      rd(OFS_SOURCE_SELECT, v);
      chk("source rb", codes[i], v);
      chk("routing", {4'h0, codes[i] == 8'h06 || codes[i] == 8'h0E, codes[i] == 8'h06,
          codes[i] == 8'h0E, codes[i] == 8'h0F},
          {4'h0, afe.sensor_enable, afe.sensor_to_pin, afe.sensor_to_conv,
          afe.pin_to_conv});
    end
  endtask

  task automatic t_modes();
    logic [7:0] vals [3] = '{8'h04, 8'h08, 8'h0D};
    foreach (vals[i])
    begin
      wr(OFS_CONTROL, vals[i]);
      rd(OFS_CONTROL, v);
      chk("control rb", vals[i], v);
      chk("mode", {5'h0, vals[i][0], vals[i][2], vals[i][3]},
          {5'h0, afe.conv_enable, afe.range_full, afe.log_response});
    end
  endtask

  task automatic t_convert();
    @(posedge ref_clk);
    analog_code <= 8'hA5;
    start_conv(4'h1);
    rd(OFS_STATUS, v);  chk("busy", 8'h02, v);
    chk("sample", 8'h01, {7'h00, afe.sample});
    wait_done();
    chk("done", 8'h01, v);
    rd(OFS_RESULT, v);  chk("result", 8'hA5, v);
    @(posedge ref_clk);
    analog_code <= 8'h5A;
    wr(OFS_CONTROL, 8'h13);
    repeat (20) @(posedge ref_clk);
    rd(OFS_STATUS, v);  chk("no edge", 8'h01, v);
    rd(OFS_RESULT, v);  chk("result hold", 8'hA5, v);
  endtask

  task automatic t_clkdiv();
    int  n;
    logic prev;
    start_conv(4'h3);
    @(posedge converter_clk);
    n = 0;
    prev = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      @(posedge ref_clk);
      #1;
      n++;
      if (!prev && converter_clk === 1'b1)
        break;
      prev = converter_clk;
    end
    chk("clk period", 8'h06, 8'(n));
    wait_done();
    rd(OFS_RESULT, v);  chk("result div3", 8'h5A, v);
  endtask

  task automatic t_powerdown();
    wr(OFS_SOURCE_SELECT, 8'h0E);
    analog_code <= 8'h3C;
    start_conv(4'h3);
    repeat (5) @(posedge ref_clk);
    power_down_pin <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("pd afe", 8'h00, {3'h0, afe.sensor_enable, afe.sensor_to_conv, afe.conv_enable,
        afe.sample, converter_clk});
    rd(OFS_STATUS, v);  chk("pd abort", 8'h00, v);
    start_conv(4'h3);
    rd(OFS_STATUS, v);  chk("pd start", 8'h00, v);
    rd(OFS_RESULT, v);  chk("pd result", 8'h5A, v);
    @(posedge ref_clk);
    power_down_pin <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("pd restore", 8'h03, {6'h0, afe.sensor_enable, afe.conv_enable});
  endtask

  task automatic t_disabled();
    wr(OFS_CONTROL, 8'h30);
    wr(OFS_CONTROL, 8'h32);
    repeat (10) @(posedge ref_clk);
    rd(OFS_STATUS, v);  chk("disabled", 8'h00, v);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    miscompares = 0;
    comparisons = 0;
    cycles = 0;
    rst = 1'b1;
    power_down_pin = 1'b0;
    analog_code = 8'h00;
    req = '{wr: 1'b0, rd: 1'b0, addr: 14'h0000, wdata: 8'h00};
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_source();
    t_modes();
    t_convert();
    t_clkdiv();
    t_powerdown();
    t_disabled();
    stop_test();
  end
endmodule
